// [rtl/stg_pkg.sv]
// Constants and types for the serial lane test pattern generator
// Function
// RULE1: Same transport patterns for both line encodings
// RULE2: 8b/10b: start after alignment, run in data
// RULE3: 64b/66b: start once serializers are initialised
// RULE4: All layouts use the short transport pattern
// RULE5: N'=8: frame0 octet k, frame1 0xFF-k
// RULE6: Only lowest-indexed enabled lanes carry the pattern
// RULE7: N'=12 word j = {0xF-k, k, j}
// RULE8: Sixteen lanes, group B repeats group A
// RULE9: D21.5 stream on both encodings
// RULE10: K28.5 stream only with 8b/10b
// RULE11: Repeated alignment sequence, never data, 8b/10b only
// RULE12: Sync request triggers code group sync, then alignment
// RULE13: Random spectral pattern: fixed twelve-octet loop
// RULE14: Encoded octet pairs give fixed 20-bit codes
// RULE15: Controller selects mode only while link disabled
// RULE16: Lane count and rate follow lane configuration
// RULE17: N'=12 tail nibble is zero
// RULE18: Invalid mode/encoding pair sends normal data
package stg_pkg;

  localparam int unsigned LANES       = 16;
  localparam int unsigned GROUP_LANES = 8;
  localparam int unsigned RSP_LEN     = 12;
  localparam logic [2:0] N8_LAST_OCTET  = 3'h0;
  localparam logic [2:0] N12_LAST_OCTET = 3'h7;
  localparam logic [3:0] RSP_LAST       = 4'hb;
  localparam logic [7:0] D21_5_OCTET    = 8'hb5;
  localparam logic [7:0] K28_5_OCTET    = 8'hbc;
  localparam logic [7:0] ALL_ONES_OCTET = 8'hff;
  localparam logic [3:0] TAIL_NIBBLE    = 4'h0;
  localparam logic [3:0] TOP_NIBBLE     = 4'hf;

  typedef enum logic [2:0] {
    STG_MODE_OFF       = 3'b000,
    STG_MODE_TRANSPORT = 3'b001,
    STG_MODE_D21_5     = 3'b010,
    STG_MODE_K28_5     = 3'b011,
    STG_MODE_ILA_RPT   = 3'b100,
    STG_MODE_RSP       = 3'b101
  } stg_mode_e;

  typedef enum logic [1:0] {
    STG_ST_IDLE = 2'b00,
    STG_ST_WAIT = 2'b01,
    STG_ST_RUN  = 2'b10
  } stg_state_e;

endpackage

// [rtl/stg_random_spectral_pattern_rom.sv]
// Twelve-octet random spectral pattern table with registered read data
`timescale 1ns/1ps
`default_nettype none
module stg_rsp_rom (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] addr_i,
  output logic      [7:0] data_o
);

  logic [7:0] data_reg;
  logic [7:0] data_next;

  // Encoder input octets; the pairs encode to fixed 20-bit codes (see RULE14)
  always_comb
  begin
    unique case (addr_i) // see RULE13
      4'h0:    data_next = 8'hbe;
      4'h1:    data_next = 8'hd7;
      4'h2:    data_next = 8'h23;
      4'h3:    data_next = 8'h47;
      4'h4:    data_next = 8'h6b;
      4'h5:    data_next = 8'h8f;
      4'h6:    data_next = 8'hb3;
      4'h7:    data_next = 8'h14;
      4'h8:    data_next = 8'h5e;
      4'h9:    data_next = 8'hfb;
      4'ha:    data_next = 8'h35;
      4'hb:    data_next = 8'h59;
      default: data_next = 8'hbe;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      data_reg <= 8'hbe;
    else
      data_reg <= data_next;
  end

  assign data_o = data_reg;

endmodule
`default_nettype wire

// [rtl/stg_pattern_gen.sv]
// Test pattern generator placed ahead of the lane encoders
`timescale 1ns/1ps
`default_nettype none
module stg_pattern_gen (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [2:0]   test_pattern_select_i,
  input  wire logic         enc_64b66b_i,
  input  wire logic         n_prime_12_i,
  input  wire logic [3:0]   lanes_per_group_i,
  input  wire logic         ila_done_i,
  input  wire logic         data_enc_state_i,
  input  wire logic         serdes_init_done_i,
  input  wire logic         sync_request_i,
  input  wire logic [127:0] lane_data_i,
  input  wire logic [15:0]  lane_ctrl_i,
  output logic      [127:0] lane_data_o,
  output logic      [15:0]  lane_ctrl_o,
  output logic      [15:0]  lane_enable_o,
  output logic              pattern_active_o,
  output logic              ila_repeat_o,
  output logic              cgs_start_o
);

  typedef struct packed {
    stg_pkg::stg_state_e state;
    logic [2:0]          octet_idx;
    logic                frame_odd;
    logic [3:0]          rsp_idx;
    logic                sync_q;
    logic [127:0]        data;
    logic [15:0]         ctrl;
    logic                active;
    logic                cgs;
  } stg_state_s;

  stg_state_s st_reg;
  stg_state_s st_next;
  logic [7:0] rsp_octet;

  // Lanes k below the per-group count are enabled in both groups
  function automatic logic [15:0] lane_mask(input logic [3:0] count);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < int'(stg_pkg::GROUP_LANES); i++)
    begin
      m[i]   = (4'(i) < count);
      m[i+8] = (4'(i) < count);
    end
    return m;
  endfunction

  // Some modes only make sense ahead of an 8b/10b encoder
  function automatic logic mode_valid(input logic [2:0] mode, input logic enc64);
    logic v;
    v = 1'b0;
    unique case (mode)
      stg_pkg::STG_MODE_TRANSPORT: v = 1'b1;                  // see RULE1
      stg_pkg::STG_MODE_D21_5:     v = 1'b1;                  // see RULE9
      stg_pkg::STG_MODE_K28_5:     v = !enc64;                // see RULE10
      stg_pkg::STG_MODE_ILA_RPT:   v = !enc64;                // see RULE11
      stg_pkg::STG_MODE_RSP:       v = !enc64;                // see RULE13
      default:                     v = 1'b0;                  // see RULE18
    endcase
    return v;
  endfunction

  // N'=12, F=8 frame: five 12-bit words then the tail nibble
  function automatic logic [7:0] n12_octet(input logic [2:0] k, input logic [2:0] o);
    logic [63:0] fv;
    fv = {stg_pkg::TOP_NIBBLE - {1'b0, k}, {1'b0, k}, 4'h1,   // see RULE7
          stg_pkg::TOP_NIBBLE - {1'b0, k}, {1'b0, k}, 4'h2,
          stg_pkg::TOP_NIBBLE - {1'b0, k}, {1'b0, k}, 4'h3,
          stg_pkg::TOP_NIBBLE - {1'b0, k}, {1'b0, k}, 4'h4,
          stg_pkg::TOP_NIBBLE - {1'b0, k}, {1'b0, k}, 4'h5,
          stg_pkg::TAIL_NIBBLE};                              // see RULE17
    return fv[6'(63 - 8 * int'(o)) -: 8];
  endfunction

  logic [15:0] mask;
  logic        valid;
  logic        is_transport;
  logic        start_ok;
  logic        keep_ok;
  logic        ila_sel;

  assign mask         = lane_mask(lanes_per_group_i);        // see RULE16
  assign valid        = mode_valid(test_pattern_select_i, enc_64b66b_i);
  assign is_transport = (test_pattern_select_i == stg_pkg::STG_MODE_TRANSPORT);
  // Repeated alignment lives in the link layer; the generator must stay out of the way
  assign ila_sel      = valid && (test_pattern_select_i == stg_pkg::STG_MODE_ILA_RPT); // see RULE11

  // 8b/10b transport patterns wait for the link; 64b/66b transport and raw streams only need the serializers
  always_comb
  begin
    if (is_transport && !enc_64b66b_i)
    begin
      start_ok = ila_done_i && data_enc_state_i;              // see RULE2
      keep_ok  = data_enc_state_i;
    end
    else
    begin
      start_ok = serdes_init_done_i;                          // see RULE3
      keep_ok  = serdes_init_done_i;
    end
  end

  always_comb
  begin
    st_next        = st_reg;
    st_next.sync_q = sync_request_i;
    st_next.cgs    = 1'b0;
    unique case (st_reg.state)
      stg_pkg::STG_ST_IDLE:
      begin
        if (valid && test_pattern_select_i != stg_pkg::STG_MODE_ILA_RPT)
          st_next.state = stg_pkg::STG_ST_WAIT;
      end
      stg_pkg::STG_ST_WAIT:
      begin
        if (!valid || ila_sel)
          st_next.state = stg_pkg::STG_ST_IDLE;
        else if (start_ok)
          st_next.state = stg_pkg::STG_ST_RUN;
      end
      stg_pkg::STG_ST_RUN:
      begin
        if (!valid || ila_sel)
          st_next.state = stg_pkg::STG_ST_IDLE;
        else if (!keep_ok)
          st_next.state = stg_pkg::STG_ST_WAIT;
      end
      default:
        st_next.state = stg_pkg::STG_ST_IDLE;
    endcase

    // Counters restart at frame 0 every time the pattern (re)starts
    if (st_reg.state == stg_pkg::STG_ST_RUN)
    begin
      if (st_reg.octet_idx == (n_prime_12_i ? stg_pkg::N12_LAST_OCTET : stg_pkg::N8_LAST_OCTET))
      begin
        st_next.octet_idx = 3'h0;
        st_next.frame_odd = !st_reg.frame_odd;
      end
      else
        st_next.octet_idx = st_reg.octet_idx + 3'h1;
      st_next.rsp_idx = (st_reg.rsp_idx == stg_pkg::RSP_LAST) ? 4'h0 : st_reg.rsp_idx + 4'h1;
    end
    else
    begin
      st_next.octet_idx = 3'h0;
      st_next.frame_odd = 1'b0;
      st_next.rsp_idx   = 4'h0;
    end

    // Repeated alignment: each new sync request restarts code group sync
    if (valid && test_pattern_select_i == stg_pkg::STG_MODE_ILA_RPT)
      st_next.cgs = sync_request_i && !st_reg.sync_q;         // see RULE12

    st_next.active = (st_reg.state == stg_pkg::STG_ST_RUN) && valid && !ila_sel && keep_ok; // see RULE11
    if (st_next.active)
    begin
      for (int l = 0; l < int'(stg_pkg::LANES); l++)
      begin
        logic [2:0] k;
        logic [7:0] oct;
        logic       kc;
        k   = 3'(l % int'(stg_pkg::GROUP_LANES));             // see RULE8
        oct = 8'h00;
        kc  = 1'b0;
        unique case (test_pattern_select_i)
          stg_pkg::STG_MODE_TRANSPORT:                        // see RULE4
            oct = n_prime_12_i ? n12_octet(k, st_reg.octet_idx)
                : (st_reg.frame_odd ? stg_pkg::ALL_ONES_OCTET - {5'h00, k} : {5'h00, k}); // see RULE5
          stg_pkg::STG_MODE_D21_5:
            oct = stg_pkg::D21_5_OCTET;
          stg_pkg::STG_MODE_K28_5:
          begin
            oct = stg_pkg::K28_5_OCTET;
            kc  = 1'b1;
          end
          stg_pkg::STG_MODE_RSP:
            oct = rsp_octet;
          default:
            oct = 8'h00;
        endcase
        st_next.data[8*l +: 8] = mask[l] ? oct : 8'h00;      // see RULE6
        st_next.ctrl[l]        = mask[l] & kc;
      end
    end
    else
    begin
      st_next.data = lane_data_i;                             // see RULE18
      st_next.ctrl = lane_ctrl_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_reg <= '{state: stg_pkg::STG_ST_IDLE, default: '0};
    else
      st_reg <= st_next;
  end

  // Address with the next index so table data lines up with the counter
  stg_rsp_rom u_rsp_rom (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .addr_i    (st_next.rsp_idx),
    .data_o    (rsp_octet)
  );

  assign lane_data_o      = st_reg.data;
  assign lane_ctrl_o      = st_reg.ctrl;
  assign lane_enable_o    = mask;
  assign pattern_active_o = st_reg.active;
  assign ila_repeat_o     = valid && (test_pattern_select_i == stg_pkg::STG_MODE_ILA_RPT);
  assign cgs_start_o      = st_reg.cgs;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_new_sync;
    ila_repeat_o && sync_request_i && !st_reg.sync_q;
  endsequence

  chk_cgs_on_sync: assert property (s_new_sync |=> cgs_start_o) // see RULE12
    else $error("sync request did not start code group sync");

  chk_no_early_start: assert property (                        // see RULE2
    (is_transport && !enc_64b66b_i && !ila_done_i && st_reg.state != stg_pkg::STG_ST_RUN) |=> !pattern_active_o)
    else $error("transport pattern before alignment done");

  sequence s_ready_64;
    is_transport && enc_64b66b_i && serdes_init_done_i && st_reg.state == stg_pkg::STG_ST_WAIT;
  endsequence

  chk_start_64b: assert property ((s_ready_64 ##1 serdes_init_done_i && is_transport) |=> pattern_active_o) // see RULE3
    else $error("64b66b transport pattern did not start");

  chk_n8_alternate: assert property (                          // see RULE5
    (pattern_active_o && is_transport && !n_prime_12_i && mask[0] && lane_data_o[7:0] == 8'h00 &&
     $stable(test_pattern_select_i) && st_reg.active == st_next.active) |=> lane_data_o[7:0] == 8'hff)
    else $error("N8 pattern did not alternate");

  chk_disabled_quiet: assert property (pattern_active_o |-> ((lane_data_o[15:8] == 8'h00) || mask[1])) // see RULE6
    else $error("disabled lane carries pattern");

  chk_k28_8b_only: assert property ((|lane_ctrl_o && pattern_active_o) |-> $past(!enc_64b66b_i)) // see RULE10
    else $error("K28.5 emitted with 64b66b");

  chk_d215_value: assert property (                            // see RULE9
    (st_next.active && test_pattern_select_i == stg_pkg::STG_MODE_D21_5 && mask[0]) |=> lane_data_o[7:0] == 8'hb5)
    else $error("D21.5 octet wrong");

  chk_invalid_pass: assert property (!valid |=> lane_data_o == $past(lane_data_i) && !pattern_active_o) // see RULE18
    else $error("invalid mode did not pass normal data");

  chk_rsp_first: assert property (                             // see RULE13
    (st_reg.state == stg_pkg::STG_ST_WAIT && st_next.state == stg_pkg::STG_ST_RUN &&
     test_pattern_select_i == stg_pkg::STG_MODE_RSP && mask[0]) ##1 (st_next.active && $stable(test_pattern_select_i))
    |=> lane_data_o[7:0] == 8'hbe)
    else $error("random spectral pattern did not start at first octet");

  // Both groups are filled from the same lane index, so they must match whenever a pattern is active
  chk_group_b_copy: assert property (pattern_active_o |-> lane_data_o[127:64] == lane_data_o[63:0]) // see RULE8
    else $error("group B lanes differ from group A");

  chk_ila_no_pattern: assert property (ila_repeat_o |=> !pattern_active_o) // see RULE11
    else $error("pattern sent during repeated alignment");

  chk_lane0_off_quiet: assert property ((pattern_active_o && !$past(mask[0])) |-> lane_data_o[7:0] == 8'h00) // see RULE6
    else $error("disabled lane 0 carries pattern");

  sequence s_n12_first_octet;
    st_next.active && is_transport && n_prime_12_i && st_reg.octet_idx == 3'h0 && mask[1];
  endsequence

  sequence s_n12_last_octet;
    st_next.active && is_transport && n_prime_12_i && st_reg.octet_idx == stg_pkg::N12_LAST_OCTET && mask[0];
  endsequence

  // Lane 1 opens each frame with word 1 = 0xE11, so its first octet is 0xE1
  chk_n12_first_word: assert property (s_n12_first_octet |=> lane_data_o[15:8] == 8'he1) // see RULE7
    else $error("N12 first octet wrong");

  chk_n12_tail_zero: assert property (s_n12_last_octet |=> lane_data_o[3:0] == stg_pkg::TAIL_NIBBLE) // see RULE17
    else $error("N12 tail nibble not zero");

  chk_k28_ctrl_set: assert property (                          // see RULE10
    (st_next.active && test_pattern_select_i == stg_pkg::STG_MODE_K28_5 && mask[0])
    |=> lane_ctrl_o[0] && lane_data_o[7:0] == stg_pkg::K28_5_OCTET)
    else $error("K28.5 lane lacks control flag");

endmodule
`default_nettype wire

// [dv/stg_rx_model.sv]
// Receiver-side model that raises sync requests
`timescale 1ns/1ps
`default_nettype none
module stg_rx_model (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic want_sync_i,
  input  wire logic ila_repeat_i,
  input  wire logic cgs_start_i,
  output logic      sync_request_o
);
  // Held until code group sync starts, as a real receiver would
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sync_request_o <= 1'b0;
    else if (cgs_start_i)
      sync_request_o <= 1'b0;
    else if (want_sync_i && ila_repeat_i)
      sync_request_o <= 1'b1;
  end
endmodule
`default_nettype wire

// [dv/stg_pattern_gen_bench.sv]
// Self-checking bench for the lane test pattern generator
`timescale 1ns/1ps
`default_nettype none
module stg_pattern_gen_bench;
  typedef struct packed {
    logic [2:0] m;
    logic       e64;
    logic       n12;
    logic [3:0] nl;
    logic       act;
  } stg_row_s;
  localparam logic [127:0] LANE_IN = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  localparam logic [15:0]  CTRL_IN = 16'ha55a;
  localparam logic [7:0]   RSP_SEQ [12] = '{8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
                                             8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};
  localparam stg_row_s ROWS [14] = '{
    '{3'h1, 1'b1, 1'b0, 4'h4, 1'b1},
    '{3'h1, 1'b0, 1'b0, 4'h4, 1'b1},
    '{3'h1, 1'b0, 1'b1, 4'h8, 1'b1},
    '{3'h1, 1'b1, 1'b1, 4'h2, 1'b1},
    '{3'h2, 1'b1, 1'b0, 4'h8, 1'b1},
    '{3'h2, 1'b0, 1'b0, 4'h1, 1'b1},
    '{3'h2, 1'b1, 1'b0, 4'h0, 1'b1},
    '{3'h3, 1'b0, 1'b0, 4'h8, 1'b1},
    '{3'h5, 1'b0, 1'b0, 4'h8, 1'b1},
    '{3'h3, 1'b1, 1'b0, 4'h8, 1'b0},
    '{3'h4, 1'b1, 1'b0, 4'h8, 1'b0},
    '{3'h5, 1'b1, 1'b0, 4'h8, 1'b0},
    '{3'h0, 1'b0, 1'b0, 4'h8, 1'b0},
    '{3'h7, 1'b0, 1'b0, 4'h8, 1'b0}};
  logic         sys_clk_i = 1'b0;
  logic         rst_n_i = 1'b0;
  logic [2:0]   sel;
  logic [3:0]   nl;
  logic         e64, n12, ila, denc, srd, want, sync, act, rpt, cgs;
  logic [127:0] dat;
  logic [15:0]  ctl, en;
  stg_row_s     hr;
  int           err_total = 0;
  int           checks_done = 0;
  int           cyc = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  stg_pattern_gen stg_pattern_gen_i (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .test_pattern_select_i(sel), .enc_64b66b_i(e64),
    .n_prime_12_i(n12), .lanes_per_group_i(nl), .ila_done_i(ila), .data_enc_state_i(denc),
    .serdes_init_done_i(srd), .sync_request_i(sync), .lane_data_i(LANE_IN), .lane_ctrl_i(CTRL_IN),
    .lane_data_o(dat), .lane_ctrl_o(ctl), .lane_enable_o(en), .pattern_active_o(act),
    .ila_repeat_o(rpt), .cgs_start_o(cgs));

  stg_rx_model stg_rx_model_i (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .want_sync_i(want), .ila_repeat_i(rpt),
    .cgs_start_i(cgs), .sync_request_o(sync));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge sys_clk_i)
  begin
    cyc++;
    // Whole run needs well under a thousand cycles
    if (cyc == 3000)
    begin
      err_total++;
      give_verdict();
    end
  end

  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic cmp_lanes(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_for(ref logic s);
    for (int n = 0; n < 8 && s !== 1'b1; n++)
      tick();
  endtask

  // Upper 16 bits: control flags, lower 128: lane octets
  function automatic logic [143:0] expect_out(input stg_row_s r, input int t);
    logic [143:0] o;
    logic [63:0]  w;
    logic [3:0]   k;
    o = '0;
    for (int l = 0; l < 16; l++)
    begin
      k = 4'(l % 8);
      w = '0;
      for (int j = 1; j <= 5; j++)
        w = {w[51:0], 4'hf - k, k, 4'(j)};
      w = {w[59:0], 4'h0};
      if (k < r.nl)
        case (r.m)
          3'h1: o[8*l +: 8] = r.n12 ? w[63 - 8*(t % 8) -: 8] : ((t % 2 == 0) ? {4'h0, k} : 8'hff - {4'h0, k});
          3'h2: o[8*l +: 8] = 8'hb5;
          3'h3: {o[128 + l], o[8*l +: 8]} = {1'b1, 8'hbc};
          3'h5: o[8*l +: 8] = RSP_SEQ[t % 12];
          default: ;
        endcase
    end
    return o;
  endfunction

  task automatic run_row(input stg_row_s r, input int idx);
    logic [143:0] e;
    logic [15:0]  me;
    {srd, ila, denc} = 3'b000;
    repeat (4) tick();
    {sel, e64, n12, nl} = {r.m, r.e64, r.n12, r.nl};
    tick();
    {srd, ila, denc} = 3'b111;
    wait_for(act);
    for (int l = 0; l < 16; l++)
      me[l] = 4'(l % 8) < r.nl;
    cmp_flag(en, me);
    cmp_flag(16'(act), 16'(r.act));
    for (int t = 0; t < 24 && r.act; t++)
    begin
      e = expect_out(r, t);
      cmp_lanes(dat, e[127:0]);
      cmp_flag(ctl, e[143:128]);
      tick();
    end
    if (!r.act)
    begin
      cmp_lanes(dat, LANE_IN);
      cmp_flag(ctl, CTRL_IN);
    end
    $display("row %0d done", idx);
  endtask

  initial
  begin
    {sel, e64, n12, nl, ila, denc, srd, want} = '0;
    repeat (16) @(posedge sys_clk_i);
    #1;
    cmp_lanes(dat, '0);
    cmp_flag(ctl | 16'({act, cgs}), 16'h0);
    rst_n_i = 1'b1;
    repeat (2) tick();
    cmp_lanes(dat, LANE_IN);
    $display("reset test done");
    foreach (ROWS[i])
      run_row(ROWS[i], i);
    // Transport start waits for alignment, restarts at frame 0
    hr = ROWS[1];
    {sel, e64, n12, nl} = {hr.m, hr.e64, hr.n12, hr.nl};
    {srd, ila, denc} = 3'b000;
    tick();
    {srd, denc} = 2'b11;
    repeat (6) tick();
    cmp_flag(16'(act), 16'h0);
    ila = 1'b1;
    wait_for(act);
    cmp_lanes(dat, expect_out(hr, 0));
    tick();
    cmp_lanes(dat, expect_out(hr, 1));
    denc = 1'b0;
    repeat (4) tick();
    cmp_flag(16'(act), 16'h0);
    denc = 1'b1;
    wait_for(act);
    cmp_lanes(dat, expect_out(hr, 0));
    $display("alignment test done");
    {srd, ila, denc} = 3'b000;
    tick();
    sel = 3'h4;
    tick();
    cmp_flag(16'(rpt), 16'h1);
    for (int i = 0; i < 2; i++)
    begin
      want = 1'b1;
      tick();
      want = 1'b0;
      wait_for(cgs);
      cmp_flag(16'(cgs), 16'h1);
      tick();
      cmp_flag(16'(cgs), 16'h0);
      cmp_flag(16'(rpt), 16'h1);
    end
    srd = 1'b1;
    repeat (4) tick();
    cmp_flag(16'(act), 16'h0);
    srd = 1'b0;
    e64 = 1'b1;
    tick();
    cmp_flag(16'(rpt), 16'h0);
    $display("repeat test done");
    give_verdict();
  end
endmodule
`default_nettype wire
